// >>> shared/spp_map.svh
// Register offsets, field positions and reset values of the serial port
`ifndef SPP_MAP_SVH
`define SPP_MAP_SVH
// ----------------------------------------
// Byte offsets on the register bus
// ----------------------------------------
`define SPP_OFS_DATA 4'h0
`define SPP_OFS_CTRL 4'h4
`define SPP_OFS_CSR 4'h8
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPP_CR_IE 7
`define SPP_CR_EN 6
`define SPP_CR_R2 5
`define SPP_CR_MS 4
`define SPP_CR_CPOL 3
`define SPP_CR_CPHA 2
`define SPP_CR_R1 1
`define SPP_CR_R0 0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SPP_CTRL_RST 8'h00
`define SPP_CSR_RST 8'h00
`define SPP_DIV_BASE 8'h02
`define SPP_BITS 4'h8
`endif

// >>> shared/spp_pkg.sv
// Types shared by the serial port modules
package spp_pkg;
    typedef enum logic [1:0] {SPP_IDLE = 2'b01, SPP_RUN = 2'b10} spp_state_e;

    typedef struct packed {
        spp_state_e st;
        logic [7:0] sh;
        logic samp;
        logic pend;
        logic [3:0] cnt;
        logic [7:0] div;
        logic sck;
        logic done;
        logic [7:0] rx;
    } spp_eng_s;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [7:0] ctrl;
        logic transfer_done_flag;
        logic write_collision_flag;
        logic overrun_flag;
        logic master_fault_flag;
        logic od;
        logic se;
        logic sl;
        logic armed;
        logic marmed;
        logic ack;
        logic irq;
        logic [7:0] rd;
        logic [7:0] rxbuf;
    } spp_regs_s;
endpackage

// >>> shared/spp_if.sv
// Link between the register block and the shift engine
`timescale 1ns/10ps
interface spp_if;
    logic master;
    logic cpol;
    logic cpha;
    logic active;
    logic load;
    logic sck_in;
    logic din;
    logic [2:0] rate;
    logic [7:0] ld_data;
    logic busy;
    logic done;
    logic sck_out;
    logic dout;
    logic [7:0] rx;
    modport ctl (output master, cpol, cpha, active, load, sck_in, din,
        rate, ld_data, input busy, done, sck_out, dout, rx);
    modport eng (input master, cpol, cpha, active, load, sck_in, din,
        rate, ld_data, output busy, done, sck_out, dout, rx);
endinterface

// >>> hw/spp_engine.sv
// Shift engine: clock generation, edge detection, 8-bit shifting
`timescale 1ns/10ps
`include "spp_map.svh"
module spp_engine
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control side
    spp_if.eng e
);
    import spp_pkg::*;

    spp_eng_s s;
    spp_eng_s n;
    logic ev;
    logic lead;
    logic smp;
    logic shf;
    logic [7:0] lim;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        n = s;
        n.done = 1'b0;
        ev = 1'b0;
        lead = 1'b0;
        // Wraps to 8'hff at the slowest rate on purpose
        lim = (`SPP_DIV_BASE << e.rate) - 8'h01;
        if (e.master)
        begin
            if (s.st == SPP_RUN)
            begin
                if (s.div == lim)
                begin
                    n.div = 8'h00;
                    n.sck = ~s.sck;
                    ev = 1'b1;
                    lead = (s.sck == e.cpol);
                end
                else
                    n.div = s.div + 8'h01;
            end
            else
            begin
                n.sck = e.cpol;
                n.div = 8'h00;
            end
        end
        else if (!e.active)
        begin
            // Parked at idle level so a later master start shows no glitch
            n.sck = e.cpol;
        end
        else
        begin
            n.sck = e.sck_in;
            ev = e.active && (e.sck_in != s.sck);
            lead = (s.sck == e.cpol);
        end
        // Master samples a cycle late: its data input lags two flops
        n.pend = e.master && ev && (lead ^ e.cpha);
        smp = e.master ? s.pend : ev && (lead ^ e.cpha);
        shf = ev && !(lead ^ e.cpha);
        if (smp)
        begin
            n.samp = e.din;
            n.cnt = s.cnt + 4'h1;
            if (e.cpha && s.cnt == `SPP_BITS - 4'h1)
            begin
                n.done = 1'b1;
                n.rx = {s.sh[6:0], e.din};
                n.sh = {s.sh[6:0], e.din};
                n.cnt = 4'h0;
            end
        end
        if (shf && (!e.cpha || s.cnt != 4'h0))
        begin
            n.sh = {s.sh[6:0], s.samp};
            if (!e.cpha && s.cnt == `SPP_BITS)
            begin
                n.done = 1'b1;
                n.rx = {s.sh[6:0], s.samp};
                n.cnt = 4'h0;
            end
        end
        if (n.done && e.master)
            n.st = SPP_IDLE;
        if (e.load && !e.busy)
        begin
            n.sh = e.ld_data;
            n.cnt = 4'h0;
            n.div = 8'h00;
            n.st = SPP_RUN;
        end
        if (!e.active)
        begin
            n.st = SPP_IDLE;
            n.cnt = 4'h0;
        end
        else if (!e.master)
            n.st = SPP_RUN;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s <= '{st: SPP_IDLE, default: '0};
        else
            s <= n;
    end

    assign e.busy = (s.st == SPP_RUN) && (e.master || s.cnt != 4'h0);
    assign e.done = s.done;
    assign e.rx = s.rx;
    assign e.sck_out = s.sck;
    assign e.dout = s.sh[7];
endmodule // spp_engine

// >>> hw/spp_top.sv
// Serial peripheral port: Avalon-MM registers, flags and pin control
// Notes on behaviour
// - Master drives SCK at programmed rate, mode
// - Idle SCK rests at the polarity level
// - Low select in master clears master and enable bits
// - Master data write loads and starts shifting
// - Completion sets done flag, interrupt if enabled
// - Master flag clears: status access, data read
// - Data writes ignored while flag unacknowledged
// - Slave data write loads shift register
// - Slave flag clears: status access, data access
// - Status register resets to zero
// - Data write during transfer flags collision
// - Byte done with flag set flags overrun
// - Select low in master flags mode fault
// - Output disable releases serial data output
// - Soft select replaces the select pin
// - Soft select level zero means selected
// - Master data write starts a byte only when idle and flag acknowledged
// - Received byte copied to read buffer
`timescale 1ns/10ps
`include "spp_map.svh"
module spp_top
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    // Interrupt request
    output logic irq
);
    import spp_pkg::*;

    spp_regs_s s;
    spp_regs_s n;
    spp_if e();
    logic req;
    logic acc;
    logic wr;
    logic rd_acc;
    logic sel_dat;
    logic sel_ctl;
    logic sel_csr;
    logic ssi_n;
    logic dat_clr;
    logic wr_ok;
    logic [7:0] rmux;
    logic [7:0] csr_val;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // One wait state so that read data comes from a flop
    assign req = avs_read || avs_write;
    assign acc = req && s.ack;
    assign wr = acc && avs_write;
    assign rd_acc = acc && avs_read;
    assign sel_dat = (avs_address == `SPP_OFS_DATA);
    assign sel_ctl = (avs_address == `SPP_OFS_CTRL);
    assign sel_csr = (avs_address == `SPP_OFS_CSR);
    assign avs_waitrequest = req && !s.ack;
    assign avs_readdata = {24'h000000, s.rd};

    assign ssi_n = s.se ? s.sl : s.s2[0];
    assign csr_val = {s.transfer_done_flag, s.write_collision_flag, s.overrun_flag, s.master_fault_flag, 1'b0, s.od, s.se,
        s.sl};

    assign dat_clr = acc && sel_dat && s.armed &&
        (!s.ctrl[`SPP_CR_MS] || avs_read);
    assign wr_ok = wr && sel_dat && !e.busy && !(s.transfer_done_flag && !s.armed);

    always_comb
    begin
        unique case (avs_address)
            `SPP_OFS_DATA: rmux = s.rxbuf;
            `SPP_OFS_CTRL: rmux = s.ctrl;
            `SPP_OFS_CSR: rmux = csr_val;
            default: rmux = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Register next state
    // ----------------------------------------
    always_comb
    begin
        n = s;
        n.s1 = {sck_in, mosi_in, miso_in, ss_n_in};
        n.s2 = s.s1;
        n.ack = req && !s.ack;
        if (req && !s.ack)
            n.rd = rmux;
        if (acc && sel_csr && (s.transfer_done_flag || s.write_collision_flag))
            n.armed = 1'b1;
        if (dat_clr)
            n.armed = 1'b0;
        n.transfer_done_flag = (s.transfer_done_flag && !dat_clr) || e.done;
        n.write_collision_flag = (s.write_collision_flag && !dat_clr) || (wr && sel_dat && e.busy);
        n.overrun_flag = (s.overrun_flag && !(rd_acc && sel_csr)) || (e.done && s.transfer_done_flag);
        n.marmed = s.master_fault_flag && ((acc && sel_ctl) ? !(wr && s.marmed) :
            s.marmed);
        n.master_fault_flag = (s.master_fault_flag && !(wr && sel_ctl && s.marmed)) ||
            (s.ctrl[`SPP_CR_MS] && !ssi_n);
        if (wr && sel_ctl)
            n.ctrl = avs_writedata[7:0];
        if (wr && sel_csr)
        begin
            n.od = avs_writedata[2];
            n.se = avs_writedata[1];
            n.sl = avs_writedata[0];
        end
        if (s.ctrl[`SPP_CR_MS] && !ssi_n)
        begin
            n.ctrl[`SPP_CR_MS] = 1'b0;
            n.ctrl[`SPP_CR_EN] = 1'b0;
        end
        if (e.done)
            n.rxbuf = e.rx;
        n.irq = s.ctrl[`SPP_CR_IE] && (s.transfer_done_flag || s.overrun_flag || s.master_fault_flag);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    // ----------------------------------------
    // Engine and pins
    // ----------------------------------------
    assign e.master = s.ctrl[`SPP_CR_MS];
    assign e.cpol = s.ctrl[`SPP_CR_CPOL];
    assign e.cpha = s.ctrl[`SPP_CR_CPHA];
    assign e.rate = {s.ctrl[`SPP_CR_R2], s.ctrl[`SPP_CR_R1],
        s.ctrl[`SPP_CR_R0]};
    assign e.active = s.ctrl[`SPP_CR_EN] && (s.ctrl[`SPP_CR_MS] || !ssi_n);
    assign e.load = wr_ok;
    assign e.ld_data = avs_writedata[7:0];
    assign e.sck_in = s.s2[3];
    assign e.din = s.ctrl[`SPP_CR_MS] ? s.s2[1] : s.s2[2];

    spp_engine u_eng
    (
        .mclk (mclk),
        .rst (rst),
        .e (e.eng)
    );

    assign sck_out = e.sck_out;
    assign sck_oe = s.ctrl[`SPP_CR_EN] && s.ctrl[`SPP_CR_MS];
    assign mosi_out = e.dout;
    assign miso_out = e.dout;
    assign mosi_oe = sck_oe && !s.od;
    assign miso_oe = s.ctrl[`SPP_CR_EN] && !s.ctrl[`SPP_CR_MS] && !ssi_n &&
        !s.od;
    assign irq = s.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence m_load_s;
        wr_ok && e.master && e.active;
    endsequence
    sequence m_run_s;
        e.busy [*2];
    endsequence

    bus_answer_a: assert property (req && !s.ack |=> !avs_waitrequest)
        else $error("bus answer not after one wait state");
    sck_idle_a: assert property (e.master && !e.busy |-> sck_out == e.cpol)
        else $error("idle clock not at polarity level");
    master_drop_a: assert property (e.master && !ssi_n |=> !e.master && !s.ctrl[`SPP_CR_EN] && s.master_fault_flag)
        else $error("low select did not drop master");
    load_start_a: assert property (m_load_s |=> m_run_s)
        else $error("master write did not start a byte");
    load_msb_a: assert property (m_load_s |=> mosi_out == $past(avs_writedata[7]))
        else $error("first bit out is not msb");
    done_flag_a: assert property (e.done |=> s.transfer_done_flag ##1 (s.irq == s.ctrl[`SPP_CR_IE] || $changed(s.ctrl[`SPP_CR_IE])))
        else $error("done flag or request missing");
    flag_hold_a: assert property (s.transfer_done_flag && !dat_clr |=> s.transfer_done_flag)
        else $error("done flag cleared without sequence");
    wr_block_a: assert property (wr && sel_dat && s.transfer_done_flag && !s.armed && !e.busy && e.master |=> !e.busy)
        else $error("data write not inhibited");
    write_collision_flag_set_a: assert property (wr && sel_dat && e.busy |=> s.write_collision_flag)
        else $error("collision not flagged");
    ovr_set_a: assert property (e.done && s.transfer_done_flag |=> s.overrun_flag && s.transfer_done_flag)
        else $error("overrun not flagged");
    od_release_a: assert property (s.od |-> !mosi_oe && !miso_oe)
        else $error("output driven while disabled");
    rx_copy_a: assert property (e.done |=> s.rxbuf == $past(e.rx))
        else $error("read buffer not updated");
endmodule // spp_top

// >>> dv/spp_slave_model.sv
// Far-side serial slave used while the port runs as master
`timescale 1ns/10ps
module spp_slave_model
(
    // Serial lines
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Set-up from the bench
    input wire logic cpol,
    input wire logic cpha,
    input wire logic load,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    logic [7:0] sh;
    initial
    begin
        miso = 1'b0;
        rx = 8'h00;
        sh = 8'h00;
    end
    // Fresh byte; phase 0 shows its first bit at once
    always @(posedge load)
    begin
        sh = tx;
        if (!cpha)
        begin
            miso = sh[7];
            sh = {sh[6:0], ~sh[0]};
        end
    end
    always @(sck)
    begin
        if ((sck !== cpol) ^ cpha)
            rx = {rx[6:0], mosi};
        else
        begin
            miso = sh[7];
            // Filler toggles so stale data never passes
            sh = {sh[6:0], ~sh[0]};
        end
    end
endmodule // spp_slave_model

// >>> dv/spp_top_tb_top.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/10ps
`include "spp_map.svh"
module spp_top_tb_top;
    import spp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, sck_out, sck_oe, mosi_out, mosi_oe;
    logic miso_in, miso_out, miso_oe, irq, sck_q;
    logic sck_in = 1'b0;
    logic mosi_in = 1'b0;
    logic ss_n_in = 1'b1;
    logic cpol_m = 1'b0;
    logic cpha_m = 1'b0;
    logic ld = 1'b0;
    logic [7:0] tx_m = 8'h00;
    logic [7:0] rx_m, b, t, got, cr;
    logic [2:0] r;
    int mismatches = 0;
    int compares = 0;
    int edges = 0;
    int busy_cyc = 0;
    int seed = 32'h7edd;
    always #10 mclk = ~mclk;
    // Link activity seen on the clock pin
    always @(posedge mclk)
    begin
        sck_q <= sck_out;
        if (sck_out !== sck_q)
            edges <= edges + 1;
        if (sck_out !== cpol_m)
            busy_cyc <= busy_cyc + 1;
    end
    spp_top u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
        .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
        .irq(irq));
    spp_slave_model u_far (.sck(sck_out), .miso(miso_in),
        .mosi(mosi_oe ? mosi_out : ~mosi_out), .cpol(cpol_m),
        .cpha(cpha_m), .load(ld), .tx(tx_m), .rx(rx_m));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [7:0] d);
        int n;
        logic w;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h0, d};
        do
        begin
            @(posedge mclk);
            w = avs_waitrequest;
            q = avs_readdata;
            n++;
        end
        while (w !== 1'b0 && n < 64);
        if (n >= 64)
            mismatches++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task automatic xfer(input logic [7:0] d);
        tx_m <= 8'($random(seed));
        ld <= 1'b1;
        @(posedge mclk);
        ld <= 1'b0;
        edges <= 0;
        busy_cyc <= 0;
        bus(1'b1, `SPP_OFS_DATA, d);
    endtask
    // Polling arms the clear, as software would
    task automatic wait_done;
        int n;
        n = 0;
        q = 32'h0;
        while (q[7] !== 1'b1 && n < 600)
        begin
            bus(1'b0, `SPP_OFS_CSR, 8'h00);
            n++;
        end
        if (n >= 600)
            mismatches++;
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdc(`SPP_OFS_CSR, 8'h00);
        rdc(4'hc, 8'h00);
        chk({sck_out, sck_oe, mosi_oe, miso_oe}, 4'h0);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            r = 3'(i % 3) | {i[0] & i[1], 2'b00};
            cr = {i[2], 1'b0, r[2], 1'b0, i[0], i[1], r[1:0]};
            cpol_m <= i[0];
            cpha_m <= i[1];
            bus(1'b1, `SPP_OFS_CTRL, cr);
            bus(1'b1, `SPP_OFS_CSR, 8'h03);
            bus(1'b1, `SPP_OFS_CTRL, cr | 8'h50);
            b = 8'($random(seed));
            xfer(b);
            chk(sck_oe, 1'b1);
            wait_done;
            chk(busy_cyc, 16 << r);
            chk(edges, 16);
            chk(sck_out, i[0]);
            chk(rx_m, b);
            chk(irq, i[2]);
            rdc(`SPP_OFS_DATA, tx_m);
            rdc(`SPP_OFS_CSR, 8'h03);
        end
        $display("master mode test done");
        cpol_m <= 1'b0;
        cpha_m <= 1'b0;
        bus(1'b1, `SPP_OFS_CTRL, 8'h80);
        bus(1'b1, `SPP_OFS_CTRL, 8'hd0);
        xfer(8'h5a);
        bus(1'b1, `SPP_OFS_DATA, 8'ha5);
        for (int n = 0; n < 300 && irq !== 1'b1; n++)
            @(posedge mclk);
        edges <= 0;
        bus(1'b1, `SPP_OFS_DATA, 8'h3c);
        repeat (40) @(posedge mclk);
        chk(edges, 0);
        rdc(`SPP_OFS_CSR, 8'hc3);
        xfer(8'hc3);
        for (int n = 0; n < 300 && edges < 16; n++)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
        rdc(`SPP_OFS_CSR, 8'he3);
        bus(1'b0, `SPP_OFS_DATA, 8'h00);
        rdc(`SPP_OFS_CSR, 8'h03);
        bus(1'b1, `SPP_OFS_CSR, 8'h07);
        @(negedge mclk);
        chk(mosi_oe, 1'b0);
        bus(1'b1, `SPP_OFS_CSR, 8'h03);
        @(negedge mclk);
        chk(mosi_oe, 1'b1);
        $display("flag test done");
        ss_n_in <= 1'b0;
        // Let the low pin pass the synchroniser first
        repeat (4) @(posedge mclk);
        rdc(`SPP_OFS_CSR, 8'h03);
        bus(1'b1, `SPP_OFS_CSR, 8'h02);
        rdc(`SPP_OFS_CSR, 8'h12);
        chk(irq, 1'b1);
        rdc(`SPP_OFS_CTRL, 8'h80);
        bus(1'b1, `SPP_OFS_CSR, 8'h03);
        bus(1'b1, `SPP_OFS_CTRL, 8'h00);
        rdc(`SPP_OFS_CSR, 8'h03);
        $display("select test done");
        ss_n_in <= 1'b1;
        bus(1'b1, `SPP_OFS_CSR, 8'h00);
        bus(1'b1, `SPP_OFS_CTRL, 8'h40);
        t = 8'($random(seed));
        b = 8'($random(seed));
        bus(1'b1, `SPP_OFS_DATA, t);
        // Select low for the byte only
        ss_n_in <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(miso_oe, 1'b1);
        for (int k = 7; k >= 0; k--)
        begin
            mosi_in <= b[k];
            repeat (4) @(posedge mclk);
            got = {got[6:0], miso_out};
            sck_in <= 1'b1;
            repeat (4) @(posedge mclk);
            sck_in <= 1'b0;
        end
        repeat (8) @(posedge mclk);
        ss_n_in <= 1'b1;
        chk(got, t);
        rdc(`SPP_OFS_CSR, 8'h80);
        bus(1'b1, `SPP_OFS_DATA, 8'h00);
        rdc(`SPP_OFS_CSR, 8'h00);
        rdc(`SPP_OFS_DATA, b);
        $display("slave mode test done");
        give_verdict;
    end
    // Whole run needs well under 20000 cycles
    initial
    begin
        #1000000;
        mismatches++;
        give_verdict;
    end
endmodule // spp_top_tb_top
